// >>> hdl/fcs_pkg.sv
package fcs_pkg;

  // ----------------------------------------------------------------
  // register map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_PARAM_INDEX = 8'h02;
  localparam logic [7:0] OFS_STATUS = 8'h06;
  localparam logic [7:0] OFS_CMD_HIGH = 8'h0A;
  localparam logic [7:0] OFS_CMD_LOW = 8'h0B;
  localparam logic [7:0] OFS_RSV_ONE = 8'h0C;
  localparam logic [7:0] OFS_RSV_FOUR = 8'h0F;
  localparam logic [7:0] OFS_OPTION = 8'h10;
  localparam logic [7:0] OFS_RSV_FIVE = 8'h11;
  localparam logic [7:0] OFS_RSV_SEVEN = 8'h13;

  // ----------------------------------------------------------------
  // status register fields
  // ----------------------------------------------------------------
  localparam int STAT_COMMAND_COMPLETE_FLAG_BIT = 7;
  localparam int STAT_ACCESS_ERROR_FLAG_BIT = 5;
  localparam int STAT_PROTECTION_VIOLATION_FLAG_BIT = 4;
  localparam int STAT_VUPPER_BIT = 1;
  localparam int STAT_VLOWER_BIT = 0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] PARAM_INDEX_RESET = 3'h0;
  localparam logic [7:0] OPTION_FAULT = 8'hFF;
  localparam logic [1:0] MARGIN_RESET = 2'h0;

  // ----------------------------------------------------------------
  // commands, indices and parameter codes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h0A;
  localparam logic [7:0] OP_UNSECURE = 8'h0B;
  localparam logic [7:0] OP_USER_MARGIN = 8'h0D;
  localparam logic [7:0] OP_FIELD_MARGIN = 8'h0E;
  localparam logic [7:0] OP_DMEM_VERIFY = 8'h10;
  localparam logic [2:0] IDX_0 = 3'h0;
  localparam logic [2:0] IDX_1 = 3'h1;
  localparam logic [2:0] IDX_2 = 3'h2;
  localparam logic [15:0] MARGIN_NORMAL = 16'h0000;
  localparam logic [15:0] MARGIN_ERASED = 16'h0001;
  localparam logic [15:0] MARGIN_PROGRAMMED = 16'h0002;
  localparam logic [1:0] BLK_PMEM = 2'h0;
  localparam logic [1:0] BLK_DMEM = 2'h1;
  localparam logic [2:0] PHRASE_ALIGNED = 3'h0;

  // operation kinds handed to the array engine
  localparam logic [1:0] OPK_SECTOR_ERASE = 2'h0;
  localparam logic [1:0] OPK_MASS_ERASE = 2'h1;
  localparam logic [1:0] OPK_BLANK_CHECK = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH0,
    ST_FETCH1,
    ST_FETCH2,
    ST_FETCH3,
    ST_CHECK,
    ST_RUN,
    ST_DONE
  } fcs_state_t;

endpackage

// >>> hdl/fcs_mem_if.sv
`timescale 1ns/100ps
interface fcs_mem_if #(parameter int AW = 3, parameter int DW = 16);
  logic we;
  logic [1:0] be;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  modport ctrl (output we, be, waddr, wdata, raddr, input rdata);
  modport mem (input we, be, waddr, wdata, raddr, output rdata);
endinterface

// >>> hdl/fcs_cmd_mem.sv
`timescale 1ns/100ps
module fcs_cmd_mem
  import fcs_pkg::*;
#(
  parameter int DEPTH = 8
)(
  input wire logic clk_sys,
  fcs_mem_if.mem port
);

  // ----------------------------------------------------------------
  // byte-lane writes, registered read
  // ----------------------------------------------------------------
  // one array per lane, so no two processes share a storage variable
  generate
    for (genvar b = 0; b < 2; b++)
    begin : g_lane
      logic [7:0] lane [DEPTH];
      always_ff @(posedge clk_sys)
      begin
        if (port.we && port.be[b])
          lane[port.waddr] <= port.wdata[b*8 +: 8];
        port.rdata[b*8 +: 8] <= lane[port.raddr];
      end
    end
  endgenerate

endmodule // fcs_cmd_mem

// >>> hdl/fcs_sequencer.sv
// The address-and-strobe port is this design's own decision.
`timescale 1ns/100ps
//
// Contract
// RULE_01: sector erase flags access error unless index was 001 at launch.
// RULE_02: sector erase flags access error for invalid address bits 17:16.
// RULE_03: sector erase flags access error when address bits 2:0 nonzero.
// RULE_04: sector erase flags protection violation for a protected sector.
// RULE_05: after erase verify, upper bit for any error, lower uncorrectable.
// RULE_06: any command not allowed in current mode flags access error.
// RULE_07: unsecure is opcode 0x0B at index 000, erases all, verifies.
// RULE_08: failed unsecure verify sets upper bit, security stays unchanged.
// RULE_09: software must not write sequencer registers while busy.
// RULE_10: writing complete flag launches; device sets it when finished.
// RULE_11: unsecure flags access error unless index was 000 at launch.
// RULE_12: unsecure flags protection violation if any memory is protected.
// RULE_13: set user margin applies level to target block then completes.
// RULE_14: data margin hits data reads; program margin hits both.
// RULE_15: level 0 normal, 1 erased-state margin, 2 programmed-state margin.
// RULE_16: margin commands flag access error for unsupported level.
// RULE_17: margin commands flag access error for invalid block code.
// RULE_18: data verify 0x10: index 0 high address, 1 start, 2 count.
// RULE_19: non-blank data section sets both verify bits, then completes.
// RULE_20: option register loads config byte at reset; fault sets all.
// RULE_21: option register readable, writes ignored.
// RULE_22: reserved registers read zero, writes ignored.
// RULE_23: command words stored per index, read back at launch.
//
module fcs_sequencer
  import fcs_pkg::*;
#(
  parameter int CMD_DEPTH = 8,
  parameter logic [3:0] PMEM_HI_VALID = 4'hC,
  parameter logic [1:0] DMEM_HI = 2'h0
)(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  input wire logic [7:0] nv_config_byte,
  input wire logic nv_config_dbe,
  input wire logic mode_cmd_allowed,
  output logic [7:0] cmd_opcode,
  output logic [17:0] target_addr,
  input wire logic addr_protected,
  input wire logic any_protected,
  output logic op_start,
  output logic [1:0] op_kind,
  output logic [15:0] op_count,
  input wire logic op_done,
  input wire logic op_err_any,
  input wire logic op_err_uncorr,
  output logic secured,
  output logic [1:0] pmem_margin,
  output logic [1:0] dmem_margin
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  generate
    if (CMD_DEPTH < 3 || CMD_DEPTH > 8)
    begin : g_bad_depth
      $error("CMD_DEPTH must be 3 to 8");
    end
  endgenerate

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  fcs_state_t state;
  logic [2:0] param_index;
  logic [2:0] launch_index;
  logic command_complete_flag;
  logic access_error_flag;
  logic protection_violation_flag;
  logic verify_status_upper;
  logic verify_status_lower;
  logic [7:0] option_register;
  logic [15:0] word0;
  logic [15:0] word1;
  logic [15:0] word2;
  logic [7:0] rd_reg;
  logic [1:0] rd_cmd_sel;

  fcs_mem_if #(.AW(3), .DW(16)) cmd_port ();

  fcs_cmd_mem #(.DEPTH(CMD_DEPTH)) u_cmd_mem (
    .clk_sys(clk_sys),
    .port(cmd_port)
  );

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire idle = command_complete_flag;
  // writes while a command runs are dropped, so a stray write
  // cannot corrupt the words the sequencer is using
  wire wr_ok = bus_wr && idle; // [RULE_09]
  wire sel_index = bus_addr == OFS_PARAM_INDEX;
  wire sel_status = bus_addr == OFS_STATUS;
  wire sel_cmd_hi = bus_addr == OFS_CMD_HIGH;
  wire sel_cmd_lo = bus_addr == OFS_CMD_LOW;
  wire sel_option = bus_addr == OFS_OPTION;
  wire wr_index = wr_ok && sel_index;
  wire wr_status = wr_ok && sel_status;
  wire clr_access_error_flag = wr_status && bus_wdata[STAT_ACCESS_ERROR_FLAG_BIT];
  wire clr_protection_violation_flag = wr_status && bus_wdata[STAT_PROTECTION_VIOLATION_FLAG_BIT];
  // a launch is held off while an old error is still standing
  wire launch = wr_status && bus_wdata[STAT_COMMAND_COMPLETE_FLAG_BIT]
    && !access_error_flag && !protection_violation_flag; // [RULE_10]

  wire [7:0] status_value = {command_complete_flag, 1'b0,
    access_error_flag, protection_violation_flag, 2'b00,
    verify_status_upper, verify_status_lower};

  // option register has no write path at all
  wire [7:0] rd_value =
    sel_index ? {5'h00, param_index} :
    sel_status ? status_value :
    sel_option ? option_register : // [RULE_21]
    8'h00; // [RULE_22]

  // ----------------------------------------------------------------
  // command word storage
  // ----------------------------------------------------------------
  assign cmd_port.we = wr_ok && (sel_cmd_hi || sel_cmd_lo); // [RULE_23]
  assign cmd_port.be = {sel_cmd_hi, sel_cmd_lo};
  assign cmd_port.waddr = param_index;
  assign cmd_port.wdata = {bus_wdata, bus_wdata};
  assign cmd_port.raddr =
    (state == ST_FETCH0) ? IDX_0 :
    (state == ST_FETCH1) ? IDX_1 :
    (state == ST_FETCH2) ? IDX_2 :
    param_index; // [RULE_23]

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      param_index <= PARAM_INDEX_RESET;
    else if (wr_index)
      param_index <= bus_wdata[2:0];
  end

  // ----------------------------------------------------------------
  // read path: data one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      rd_reg <= 8'h00;
      rd_cmd_sel <= 2'b00;
    end
    else
    begin
      rd_reg <= bus_rd ? rd_value : 8'h00;
      rd_cmd_sel <= bus_rd ? {sel_cmd_hi, sel_cmd_lo} : 2'b00;
    end
  end

  // command words come straight from the memory output register
  assign bus_rdata =
    rd_cmd_sel[1] ? cmd_port.rdata[15:8] :
    rd_cmd_sel[0] ? cmd_port.rdata[7:0] :
    rd_reg;

  // ----------------------------------------------------------------
  // option register, caught while reset is held
  // ----------------------------------------------------------------
  // needs the clock running during reset; the byte is sampled on
  // every clock edge while reset is held and holds its last value afterwards
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      option_register <= nv_config_dbe ? OPTION_FAULT
        : nv_config_byte; // [RULE_20]
  end

  // ----------------------------------------------------------------
  // launch checks
  // ----------------------------------------------------------------
  wire [7:0] opcode = word0[15:8];
  wire [1:0] addr_hi = word0[1:0];
  wire [1:0] blk_code = word0[1:0];
  wire is_erase = opcode == OP_SECTOR_ERASE;
  wire is_unsec = opcode == OP_UNSECURE; // [RULE_07]
  wire is_margin = opcode == OP_USER_MARGIN
    || opcode == OP_FIELD_MARGIN;
  wire is_dverify = opcode == OP_DMEM_VERIFY; // [RULE_18]
  wire known_op = is_erase || is_unsec || is_margin || is_dverify;

  wire erase_acc = launch_index != IDX_1 // [RULE_01]
    || !PMEM_HI_VALID[addr_hi] // [RULE_02]
    || word1[2:0] != PHRASE_ALIGNED; // [RULE_03]
  wire unsec_acc = launch_index != IDX_0; // [RULE_11]
  wire blk_ok = blk_code == BLK_PMEM || blk_code == BLK_DMEM;
  wire level_ok = word1 == MARGIN_NORMAL
    || word1 == MARGIN_ERASED
    || word1 == MARGIN_PROGRAMMED; // [RULE_15]
  wire margin_acc = launch_index != IDX_1
    || !blk_ok // [RULE_17]
    || !level_ok; // [RULE_16]
  wire dverify_acc = launch_index != IDX_2 || addr_hi != DMEM_HI;

  wire acc_err = !mode_cmd_allowed // [RULE_06]
    || !known_op
    || (is_erase && erase_acc)
    || (is_unsec && unsec_acc)
    || (is_margin && margin_acc)
    || (is_dverify && dverify_acc);
  wire viol_err = (is_erase && addr_protected) // [RULE_04]
    || (is_unsec && any_protected); // [RULE_12]

  wire check_fail = acc_err || viol_err;
  wire start_op = state == ST_CHECK && !check_fail && !is_margin;
  wire set_margin = state == ST_CHECK && !check_fail && is_margin;

  assign target_addr = {addr_hi, word1};
  assign op_count = word2;
  assign cmd_opcode = opcode;
  assign op_start = start_op;
  assign op_kind = is_unsec ? OPK_MASS_ERASE :
    is_dverify ? OPK_BLANK_CHECK : OPK_SECTOR_ERASE;

  // ----------------------------------------------------------------
  // sequencer state machine
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      state <= ST_IDLE;
    else
    begin
      case (state)
        ST_IDLE: state <= launch ? ST_FETCH0 : ST_IDLE;
        ST_FETCH0: state <= ST_FETCH1;
        ST_FETCH1: state <= ST_FETCH2;
        ST_FETCH2: state <= ST_FETCH3;
        ST_FETCH3: state <= ST_CHECK;
        ST_CHECK: state <= start_op ? ST_RUN : ST_DONE;
        ST_RUN: state <= op_done ? ST_DONE : ST_RUN;
        ST_DONE: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // words are read one cycle after their address is presented
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      word0 <= 16'h0000;
      word1 <= 16'h0000;
      word2 <= 16'h0000;
      launch_index <= IDX_0;
    end
    else
    begin
      if (launch)
        launch_index <= param_index;
      if (state == ST_FETCH1)
        word0 <= cmd_port.rdata; // [RULE_23]
      if (state == ST_FETCH2)
        word1 <= cmd_port.rdata;
      if (state == ST_FETCH3)
        word2 <= cmd_port.rdata;
    end
  end

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  wire op_end = state == ST_RUN && op_done;
  wire blank_fail = op_end && is_dverify && op_err_any;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      command_complete_flag <= 1'b1;
    else if (state == ST_DONE)
      command_complete_flag <= 1'b1; // [RULE_10] [RULE_13] [RULE_19]
    else if (launch)
      command_complete_flag <= 1'b0; // [RULE_10]
  end

  // the sets only happen while busy and the clears only while idle,
  // so a set and a clear can never meet in one cycle
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      access_error_flag <= 1'b0;
      protection_violation_flag <= 1'b0;
    end
    else
    begin
      if (state == ST_CHECK && acc_err)
        access_error_flag <= 1'b1;
      else if (clr_access_error_flag)
        access_error_flag <= 1'b0;
      if (state == ST_CHECK && viol_err)
        protection_violation_flag <= 1'b1;
      else if (clr_protection_violation_flag)
        protection_violation_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      verify_status_upper <= 1'b0;
      verify_status_lower <= 1'b0;
    end
    else if (launch)
    begin
      verify_status_upper <= 1'b0;
      verify_status_lower <= 1'b0;
    end
    else if (op_end)
    begin
      verify_status_upper <= op_err_any; // [RULE_05] [RULE_08] [RULE_19]
      verify_status_lower <= op_err_uncorr || blank_fail; // [RULE_05]
    end
  end

  // ----------------------------------------------------------------
  // security and read margins
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      secured <= 1'b1;
    else if (op_end && is_unsec && !op_err_any)
      secured <= 1'b0; // [RULE_07] [RULE_08]
  end

  // a program-memory margin is written into both levels, so data
  // reads follow it too; a data margin leaves program reads alone
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      pmem_margin <= MARGIN_RESET;
      dmem_margin <= MARGIN_RESET;
    end
    else if (set_margin)
    begin
      if (blk_code == BLK_PMEM)
        pmem_margin <= word1[1:0]; // [RULE_13] [RULE_14]
      dmem_margin <= word1[1:0]; // [RULE_14] [RULE_15]
    end
  end

endmodule // fcs_sequencer

// >>> dv/fcs_seq_chk.sv
`timescale 1ns/100ps
module fcs_seq_chk
  import fcs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rdata,
  input wire logic [7:0] nv_config_byte,
  input wire logic nv_config_dbe,
  input wire logic mode_cmd_allowed,
  input wire logic [7:0] cmd_opcode,
  input wire logic [17:0] target_addr,
  input wire logic addr_protected,
  input wire logic any_protected,
  input wire logic op_start,
  input wire logic [1:0] op_kind,
  input wire logic op_done,
  input wire logic op_err_any,
  input wire logic secured,
  input wire logic [1:0] pmem_margin,
  input wire logic [1:0] dmem_margin
);
  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  logic [7:0] opt_exp;
  wire rsv_w = (bus_addr >= OFS_RSV_ONE && bus_addr <= OFS_RSV_FOUR) ||
    (bus_addr >= OFS_RSV_FIVE && bus_addr <= OFS_RSV_SEVEN);
  wire launch_w = bus_wr && bus_addr == OFS_STATUS && bus_wdata[7];
  // strap image follows the pins for as long as reset is held
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      opt_exp <= nv_config_dbe ? OPTION_FAULT : nv_config_byte;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence rd_opt_s;
    bus_rd && bus_addr == OFS_OPTION;
  endsequence
  sequence rd_rsv_s;
    bus_rd && rsv_w;
  endsequence
  sequence erase_run_s;
    op_start ##1 op_kind == OPK_SECTOR_ERASE;
  endsequence
  sequence mass_run_s;
    op_start ##1 op_kind == OPK_MASS_ERASE;
  endsequence
  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  rsv_zero_a: assert property (rd_rsv_s |=> bus_rdata == 8'h00)
    else $error("reserved read not zero");
  opt_read_a: assert property (rd_opt_s |=> bus_rdata == opt_exp)
    else $error("option read differs from strap");
  start_cause_a: assert property (op_start |->
    $past(launch_w, 5) || $past(launch_w, 6))
    else $error("engine start without launch");
  start_mode_a: assert property (op_start |-> mode_cmd_allowed)
    else $error("engine start in forbidden mode");
  erase_ok_a: assert property (erase_run_s |->
    !$past(addr_protected) && target_addr[2:0] == 3'h0 && target_addr[17])
    else $error("bad sector erase started");
  mass_ok_a: assert property (mass_run_s |->
    !$past(any_protected) && cmd_opcode == OP_UNSECURE)
    else $error("bad unsecure started");
  unsec_good_a: assert property ($fell(secured) |->
    $past(op_done) && !$past(op_err_any) && op_kind == OPK_MASS_ERASE)
    else $error("security released without good verify");
  margin_tie_a: assert property ($changed(pmem_margin) |->
    dmem_margin == pmem_margin)
    else $error("program margin did not reach data reads");
  margin_legal_a: assert property (pmem_margin != 2'h3 &&
    dmem_margin != 2'h3)
    else $error("margin level out of range");
endmodule // fcs_seq_chk

// >>> dv/tb_flash_command_sequencer.sv
`timescale 1ns/100ps
module tb_flash_command_sequencer import fcs_pkg::*;;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] bus_addr = 8'h00, bus_wdata = 8'h00, nv_config_byte = 8'h5A;
  logic bus_wr = 1'b0, bus_rd = 1'b0, nv_config_dbe = 1'b0;
  logic mode_cmd_allowed = 1'b1, addr_protected = 1'b0, any_protected = 1'b0;
  logic op_done = 1'b0, op_err_any = 1'b0, op_err_uncorr = 1'b0;
  logic [7:0] bus_rdata, cmd_opcode, rv;
  logic [17:0] target_addr;
  logic op_start, secured;
  logic [1:0] op_kind, pmem_margin, dmem_margin;
  logic [15:0] op_count;
  logic [3:0] eng_cnt = 4'h0;
  int n_fail = 0, checks_done = 0;
  // {opcode word, level, pmem, dmem, status}
  localparam logic [43:0] MT [8] = '{
    {16'h0D00, 16'h0001, 4'h5, 8'h80}, {16'h0D01, 16'h0002, 4'h6, 8'h80},
    {16'h0E00, 16'h0002, 4'hA, 8'h80}, {16'h0E01, 16'h0001, 4'h9, 8'h80},
    {16'h0D00, 16'h0000, 4'h0, 8'h80}, {16'h0D00, 16'h0003, 4'h0, 8'hA0},
    {16'h0D02, 16'h0001, 4'h0, 8'hA0}, {16'h0E03, 16'h0000, 4'h0, 8'hA0}};
  always #20 clk_sys = ~clk_sys;
  fcs_sequencer i_dut (.clk_sys, .rst_n, .bus_addr, .bus_wdata, .bus_wr,
    .bus_rd, .bus_rdata, .nv_config_byte, .nv_config_dbe, .mode_cmd_allowed,
    .cmd_opcode, .target_addr, .addr_protected, .any_protected, .op_start,
    .op_kind, .op_count, .op_done, .op_err_any, .op_err_uncorr, .secured,
    .pmem_margin, .dmem_margin);
  // --------------------------------------------------------------
  // array engine stand-in: fixed four-cycle operation
  // --------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (op_start)
      eng_cnt <= 4'h3;
    else if (eng_cnt != 4'h0)
      eng_cnt <= eng_cnt - 4'h1;
    op_done <= (eng_cnt == 4'h1);
  end
  // --------------------------------------------------------------
  // bus and check tasks
  // --------------------------------------------------------------
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      n_fail++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk_sys);
    bus_wr <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe: sample mid-cycle
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clk_sys);
    bus_rd <= 1'b0;
    @(negedge clk_sys);
    rv = bus_rdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(rv, e);
  endtask
  task automatic wait_idle;
    int i;
    for (i = 0; i < 40; i++)
    begin
      rd(OFS_STATUS);
      if (rv[STAT_COMMAND_COMPLETE_FLAG_BIT] === 1'b1)
        break;
    end
    if (i == 40)
    begin
      $display("[ERR] %0t got %h exp %h", $time, rv, 8'h80);
      n_fail++;
      complete_run;
    end
  endtask
  // cfg = {mode, sector prot, any prot, err any, err uncorr}
  task automatic run(input logic [15:0] w0, input logic [15:0] w1,
    input logic [15:0] w2, input logic [2:0] ix, input logic [4:0] cfg,
    input logic [7:0] exp);
    logic [47:0] ws;
    ws = {w0, w1, w2};
    @(posedge clk_sys);
    {mode_cmd_allowed, addr_protected, any_protected, op_err_any,
      op_err_uncorr} <= cfg;
    for (int k = 0; k < 3; k++)
    begin
      wr(OFS_PARAM_INDEX, 8'(k));
      wr(OFS_CMD_HIGH, ws[47-16*k -: 8]);
      wr(OFS_CMD_LOW, ws[39-16*k -: 8]);
    end
    wr(OFS_PARAM_INDEX, {5'h00, ix});
    wr(OFS_STATUS, 8'h80);
    wait_idle;
    chk(rv, exp);
    // flags left standing would refuse the next launch
    if (rv[5] | rv[4])
      wr(OFS_STATUS, 8'h30);
  endtask
  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic s_reset;
    rchk(OFS_STATUS, 8'h80);
    rchk(OFS_OPTION, 8'h5A);
    chk({secured, pmem_margin, dmem_margin}, 5'h10);
  endtask
  task automatic s_regs;
    wr(OFS_OPTION, 8'hC3);
    rchk(OFS_OPTION, 8'h5A);
    for (logic [7:0] a = 8'h0C; a < 8'h14; a++)
    begin
      wr(a, 8'hFF);
      if (a != OFS_OPTION)
        rchk(a, 8'h00);
    end
    rchk(8'h30, 8'h00);
    wr(OFS_PARAM_INDEX, 8'h03);
    wr(OFS_CMD_HIGH, 8'hA5);
    wr(OFS_CMD_LOW, 8'h3C);
    wr(OFS_PARAM_INDEX, 8'h04);
    wr(OFS_CMD_HIGH, 8'h96);
    rchk(OFS_CMD_HIGH, 8'h96);
    wr(OFS_PARAM_INDEX, 8'h03);
    rchk(OFS_CMD_HIGH, 8'hA5);
    rchk(OFS_CMD_LOW, 8'h3C);
  endtask
  task automatic s_erase;
    run(16'h0A02, 16'h0000, 16'h0000, 1, 5'b10010, 8'h82);
    run(16'h0A03, 16'h0108, 16'h0000, 1, 5'b10011, 8'h83);
    run(16'h0A02, 16'h0000, 16'h0000, 2, 5'b10000, 8'hA0);
    run(16'h0A00, 16'h0000, 16'h0000, 1, 5'b10000, 8'hA0);
    run(16'h0A02, 16'h0004, 16'h0000, 1, 5'b10000, 8'hA0);
    run(16'h0A02, 16'h0000, 16'h0000, 1, 5'b11000, 8'h90);
    run(16'h0A02, 16'h0000, 16'h0000, 1, 5'b00000, 8'hA0);
    run(16'h7700, 16'h0000, 16'h0000, 0, 5'b10000, 8'hA0);
  endtask
  task automatic s_margin;
    for (int i = 0; i < 8; i++)
    begin
      run(MT[i][43:28], MT[i][27:12], 16'h0000, 1, 5'b10000,
        MT[i][7:0]);
      chk({pmem_margin, dmem_margin}, MT[i][11:8]);
    end
  endtask
  task automatic s_dver;
    run(16'h1000, 16'h0040, 16'h0005, 2, 5'b10010, 8'h83);
    chk({op_kind, target_addr}, {OPK_BLANK_CHECK, 18'h00040});
    chk(op_count, 16'h0005);
    run(16'h1000, 16'h0040, 16'h0005, 2, 5'b10000, 8'h80);
  endtask
  task automatic s_unsec;
    run(16'h0B00, 16'h0000, 16'h0000, 0, 5'b10010, 8'h82);
    chk(secured, 1'b1);
    run(16'h0B00, 16'h0000, 16'h0000, 1, 5'b10000, 8'hA0);
    run(16'h0B00, 16'h0000, 16'h0000, 0, 5'b10100, 8'h90);
    run(16'h0B00, 16'h0000, 16'h0000, 0, 5'b10000, 8'h80);
    chk({secured, op_kind}, {1'b0, OPK_MASS_ERASE});
  endtask
  task automatic s_reset2;
    @(posedge clk_sys);
    rst_n <= 1'b0;
    nv_config_dbe <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    rchk(OFS_OPTION, 8'hFF);
    chk(secured, 1'b1);
  endtask
  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    s_reset;
    s_regs;
    s_erase;
    s_margin;
    s_dver;
    s_unsec;
    s_reset2;
    complete_run;
  end
endmodule // tb_flash_command_sequencer
bind fcs_sequencer fcs_seq_chk i_chk (.clk_sys, .rst_n, .bus_addr,
  .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .nv_config_byte, .nv_config_dbe,
  .mode_cmd_allowed, .cmd_opcode, .target_addr, .addr_protected,
  .any_protected, .op_start, .op_kind, .op_done, .op_err_any, .secured,
  .pmem_margin, .dmem_margin);
